// [src/psc_host.sv]
// Host controller that drives a 512K x 16 pseudo-static RAM through its pins.
`timescale 1ns/1ps
module psc_host #(
	parameter bit SPEED_70 = 1'b0,
	parameter int ADDR_W = psc_pkg::ADDR_W,
	parameter int DATA_W = psc_pkg::DATA_W
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_wdata,
	input wire logic [1:0] req_lanes,
	output logic rsp_valid,
	output logic rsp_write,
	output logic [DATA_W-1:0] rsp_rdata,
	output logic mem_addr_o,
	output logic [ADDR_W-1:0] mem_addr,
	output logic primary_select_n,
	output logic secondary_select,
	output logic output_drive_enable_n,
	output logic write_strobe_n,
	output logic low_byte_lane_n,
	output logic high_byte_lane_n,
	input wire logic [DATA_W-1:0] mem_data_i,
	output logic [DATA_W-1:0] mem_data_o,
	output logic mem_data_oe
);

	// ------------------------------------------------------------
	// Grade-dependent phase lengths
	// ------------------------------------------------------------
	localparam int C_ACCESS = SPEED_70 ? psc_pkg::C70_ACCESS : psc_pkg::C55_ACCESS;
	localparam int C_STROBE = SPEED_70 ? psc_pkg::C70_STROBE : psc_pkg::C55_STROBE;
	localparam int C_FLOAT = SPEED_70 ? psc_pkg::C70_FLOAT : psc_pkg::C55_FLOAT;
	localparam int C_RCYCLE = SPEED_70 ? psc_pkg::C70_READ_CYCLE : psc_pkg::C55_READ_CYCLE;
	localparam int C_WAIT = C_ACCESS + psc_pkg::SYNC_STAGES;
	localparam int C_REC = psc_pkg::max2(C_FLOAT, psc_pkg::C_GAP);
	localparam logic [psc_pkg::TMR_W-1:0] LD_STROBE = psc_pkg::TMR_W'(C_STROBE - 1);
	localparam logic [psc_pkg::TMR_W-1:0] LD_WAIT = psc_pkg::TMR_W'(C_WAIT - 1);
	localparam logic [psc_pkg::TMR_W-1:0] LD_REC = psc_pkg::TMR_W'(C_REC - 1);

	psc_pkg::psc_state_t state;
	psc_pkg::psc_state_t next_state;
	logic op_write;
	logic [1:0] op_lanes;
	logic [DATA_W-1:0] din_s1;
	logic [DATA_W-1:0] din_s2;
	logic [DATA_W-1:0] din_s3;
	logic data_stable;
	logic [DATA_W-1:0] lane_mask;
	logic [1:0] lane_n;
	logic sel_phase;
	logic [psc_pkg::TMR_W-1:0] access_cycles;
	logic spacing_met;

	psc_timer_if tif ();

	psc_timer u_timer (
		.clock(clock),
		.srst(srst),
		.tif(tif)
	);

	// ------------------------------------------------------------
	// Phase sequencing
	// ------------------------------------------------------------
	assign req_ready = (state == psc_pkg::PSC_IDLE);
	assign data_stable = (din_s2 == din_s3);
	// The selects and lanes are active in every phase from setup to sample.
	assign sel_phase = (next_state == psc_pkg::PSC_SETUP) || (next_state == psc_pkg::PSC_STROBE)
		|| (next_state == psc_pkg::PSC_WHOLD) || (next_state == psc_pkg::PSC_ACCESS)
		|| (next_state == psc_pkg::PSC_SAMPLE);

	always_comb begin
		next_state = state;
		tif.load = 1'b0;
		tif.value = '0;
		case (state)
			psc_pkg::PSC_IDLE: begin
				if (req_valid) begin
					next_state = psc_pkg::PSC_SETUP;
				end
			end
			// Address, selects and lanes settle one cycle before the strobe or wait.
			psc_pkg::PSC_SETUP: begin
				tif.load = 1'b1;
				if (op_write) begin
					next_state = psc_pkg::PSC_STROBE;
					tif.value = LD_STROBE;
				end else begin
					next_state = psc_pkg::PSC_ACCESS;
					tif.value = LD_WAIT;
				end
			end
			psc_pkg::PSC_STROBE: begin
				if (tif.done) begin
					next_state = psc_pkg::PSC_WHOLD;
				end
			end
			psc_pkg::PSC_WHOLD: begin
				next_state = psc_pkg::PSC_RECOVER;
				tif.load = 1'b1;
				tif.value = LD_REC;
			end
			psc_pkg::PSC_ACCESS: begin
				if (tif.done) begin
					next_state = psc_pkg::PSC_SAMPLE;
				end
			end
			psc_pkg::PSC_SAMPLE: begin
				if (data_stable) begin
					next_state = psc_pkg::PSC_RECOVER;
					tif.load = 1'b1;
					tif.value = LD_REC;
				end
			end
			psc_pkg::PSC_RECOVER: begin
				if (tif.done && spacing_met) begin
					next_state = psc_pkg::PSC_IDLE;
				end
			end
			default: begin
				next_state = psc_pkg::PSC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state <= psc_pkg::PSC_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// Request capture
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			op_write <= 1'b0;
			op_lanes <= 2'b00;
		end else if (req_valid && req_ready) begin
			op_write <= req_write;
			op_lanes <= req_lanes;
		end
	end

	// ------------------------------------------------------------
	// Read cycle spacing
	// ------------------------------------------------------------
	// Counts edges since the request was taken, so recovery can never end
	// before a full read cycle has passed, whatever the phase lengths are.
	always_ff @(posedge clock) begin
		if (srst) begin
			access_cycles <= '0;
		end else if (req_valid && req_ready) begin
			access_cycles <= psc_pkg::TMR_W'(1);
		end else if (access_cycles != '1) begin
			access_cycles <= access_cycles + 1'b1;
		end
	end

	assign spacing_met = (access_cycles >= psc_pkg::TMR_W'(C_RCYCLE));

	// ------------------------------------------------------------
	// Address pins
	// ------------------------------------------------------------
	// The address is loaded when the request is taken and held until the next
	// one, so it changes on the same edge as the select fall and is stable across strobe and the following hold.
	always_ff @(posedge clock) begin
		if (srst) begin
			mem_addr <= psc_pkg::ADDR_RESET;
		end else if (req_valid && req_ready) begin
			mem_addr <= req_addr;
		end
	end

	assign mem_addr_o = 1'b1;

	// ------------------------------------------------------------
	// Select, lane and enable pins
	// ------------------------------------------------------------
	// Selects drop in recovery and idle, which gives the memory its refresh
	// window after every access and bounds the select low time of every write.
	always_ff @(posedge clock) begin
		if (srst) begin
			primary_select_n <= 1'b1;
			secondary_select <= 1'b0;
		end else if (sel_phase) begin
			primary_select_n <= 1'b0;
			secondary_select <= 1'b1;
		end else begin
			primary_select_n <= 1'b1;
			secondary_select <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Byte lane pins
	// ------------------------------------------------------------
	// A lane takes the request's choice at the take edge and the stored choice
	// after it; it rises with the selects, so no lane stays low in recovery.
	for (genvar g = 0; g < 2; g++) begin : g_lane
		logic lane_q;

		always_ff @(posedge clock) begin
			if (srst) begin
				lane_q <= 1'b1;
			end else if (next_state == psc_pkg::PSC_SETUP) begin
				lane_q <= ~req_lanes[g];
			end else if (sel_phase) begin
				lane_q <= ~op_lanes[g];
			end else begin
				lane_q <= 1'b1;
			end
		end

		assign lane_n[g] = lane_q;
		assign lane_mask[g*(DATA_W/2) +: DATA_W/2] = {(DATA_W/2){op_lanes[g]}};
	end

	assign low_byte_lane_n = lane_n[0];
	assign high_byte_lane_n = lane_n[1];

	// Output enable is held high during writes, so the memory never drives
	// against the write data.
	always_ff @(posedge clock) begin
		if (srst) begin
			output_drive_enable_n <= 1'b1;
		end else if ((next_state == psc_pkg::PSC_SETUP && !req_write)
			|| next_state == psc_pkg::PSC_ACCESS || next_state == psc_pkg::PSC_SAMPLE) begin
			output_drive_enable_n <= 1'b0;
		end else begin
			output_drive_enable_n <= 1'b1;
		end
	end

	// The strobe only falls for writes, after setup, and rises one cycle before
	// the selects and lanes, so the strobe edge ends the write.
	always_ff @(posedge clock) begin
		if (srst) begin
			write_strobe_n <= 1'b1;
		end else if (next_state == psc_pkg::PSC_STROBE) begin
			write_strobe_n <= 1'b0;
		end else begin
			write_strobe_n <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Data pins
	// ------------------------------------------------------------
	// Write data is driven from setup through the hold cycle, and released a
	// float time before the memory may be selected for a read again.
	always_ff @(posedge clock) begin
		if (srst) begin
			mem_data_o <= psc_pkg::DATA_RESET;
			mem_data_oe <= 1'b0;
		end else if (next_state == psc_pkg::PSC_SETUP) begin
			mem_data_o <= req_wdata;
			mem_data_oe <= req_write;
		end else if (next_state == psc_pkg::PSC_STROBE || next_state == psc_pkg::PSC_WHOLD) begin
			mem_data_oe <= op_write;
		end else begin
			mem_data_oe <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			din_s1 <= psc_pkg::DATA_RESET;
			din_s2 <= psc_pkg::DATA_RESET;
			din_s3 <= psc_pkg::DATA_RESET;
		end else begin
			din_s1 <= mem_data_i;
			din_s2 <= din_s1;
			din_s3 <= din_s2;
		end
	end

	// ------------------------------------------------------------
	// Answers
	// ------------------------------------------------------------
	// Lanes that were not asked for read back as zero.

	always_ff @(posedge clock) begin
		if (srst) begin
			rsp_valid <= 1'b0;
			rsp_write <= 1'b0;
			rsp_rdata <= psc_pkg::DATA_RESET;
		end else if (state == psc_pkg::PSC_SAMPLE && data_stable) begin
			rsp_valid <= 1'b1;
			rsp_write <= 1'b0;
			rsp_rdata <= din_s3 & lane_mask;
		end else if (state == psc_pkg::PSC_WHOLD) begin
			rsp_valid <= 1'b1;
			rsp_write <= 1'b1;
			rsp_rdata <= psc_pkg::DATA_RESET;
		end else begin
			rsp_valid <= 1'b0;
		end
	end

	// Read cycle spacing: setup plus wait plus recovery always exceeds the
	// read cycle time, so consecutive reads never start too close.
	localparam bit RCYCLE_MET = (1 + C_WAIT + C_REC) >= C_RCYCLE;
	localparam bit STROBE_MET = C_STROBE <= psc_pkg::C_STROBE_MAX;

endmodule

// [src/psc_pkg.sv]
// Constants shared by the pseudo-static RAM host controller.
package psc_pkg;

	// ------------------------------------------------------------
	// Clock and widths
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int ADDR_W = 19;
	localparam int DATA_W = 16;
	localparam int TMR_W = 8;
	localparam int SYNC_STAGES = 3;

	// ------------------------------------------------------------
	// Times in ns, per speed grade
	// ------------------------------------------------------------
	localparam int T55_ACCESS_NS = 55;
	localparam int T70_ACCESS_NS = 70;
	localparam int T55_READ_CYCLE_NS = 55;
	localparam int T70_READ_CYCLE_NS = 70;
	localparam int T55_STROBE_NS = 45;
	localparam int T70_STROBE_NS = 60;
	localparam int T55_STROBE_HZ_NS = 20;
	localparam int T70_STROBE_HZ_NS = 30;
	localparam int T55_DATA_SETUP_NS = 25;
	localparam int T70_DATA_SETUP_NS = 30;
	localparam int T55_FLOAT_NS = 20;
	localparam int T70_FLOAT_NS = 25;
	localparam int T_STROBE_MAX_NS = 15000;
	localparam int T_GAP_NS = 5;

	function automatic int ceil_cycles(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int max2(input int a, input int b);
		return (a > b) ? a : b;
	endfunction

	// ------------------------------------------------------------
	// Cycle counts derived from the times
	// ------------------------------------------------------------
	localparam int C55_ACCESS = ceil_cycles(T55_ACCESS_NS);
	localparam int C70_ACCESS = ceil_cycles(T70_ACCESS_NS);
	localparam int C55_READ_CYCLE = ceil_cycles(T55_READ_CYCLE_NS);
	localparam int C70_READ_CYCLE = ceil_cycles(T70_READ_CYCLE_NS);
	localparam int C55_STROBE = max2(ceil_cycles(T55_STROBE_NS),
		ceil_cycles(T55_STROBE_HZ_NS + T55_DATA_SETUP_NS) + 1);
	localparam int C70_STROBE = max2(ceil_cycles(T70_STROBE_NS),
		ceil_cycles(T70_STROBE_HZ_NS + T70_DATA_SETUP_NS) + 1);
	localparam int C_STROBE_MAX = T_STROBE_MAX_NS / CLK_PERIOD_NS;
	localparam int C55_FLOAT = ceil_cycles(T55_FLOAT_NS);
	localparam int C70_FLOAT = ceil_cycles(T70_FLOAT_NS);
	localparam int C_GAP = ceil_cycles(T_GAP_NS);

	// ------------------------------------------------------------
	// Reset values of the pins
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_RESET = 19'h0_0000;
	localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

	typedef enum logic [2:0] {
		PSC_IDLE = 3'b000,
		PSC_SETUP = 3'b001,
		PSC_STROBE = 3'b010,
		PSC_WHOLD = 3'b011,
		PSC_ACCESS = 3'b100,
		PSC_SAMPLE = 3'b101,
		PSC_RECOVER = 3'b110
	} psc_state_t;

endpackage

// [src/psc_timer_if.sv]
// Interface between the controller and its phase timer.
`timescale 1ns/1ps
interface psc_timer_if;
	logic load;
	logic [psc_pkg::TMR_W-1:0] value;
	logic done;

	modport ctrl (output load, output value, input done);
	modport timer (input load, input value, output done);
endinterface

// [src/psc_timer.sv]
// Down counter that times the strobe, access and recovery phases of a memory access.
`timescale 1ns/1ps
module psc_timer (
	input wire logic clock,
	input wire logic srst,
	psc_timer_if.timer tif
);

	logic [psc_pkg::TMR_W-1:0] count;

	// A load sets the count for the phase now starting; done marks its last cycle.
	always_ff @(posedge clock) begin
		if (srst) begin
			count <= '0;
		end else if (tif.load) begin
			count <= tif.value;
		end else if (count != '0) begin
			count <= count - 1'b1;
		end
	end

	assign tif.done = (count == '0) && !tif.load;

endmodule

// [sim/psc_host_props.sv]
// Checker of the pin timing of the pseudo-static RAM host controller.
`timescale 1ns/1ps
module psc_host_props #(
	parameter bit SPEED_70 = 1'b0
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic req_write,
	input wire logic [psc_pkg::ADDR_W-1:0] req_addr,
	input wire logic [psc_pkg::DATA_W-1:0] req_wdata,
	input wire logic [1:0] req_lanes,
	input wire logic rsp_valid,
	input wire logic rsp_write,
	input wire logic [psc_pkg::ADDR_W-1:0] mem_addr,
	input wire logic primary_select_n,
	input wire logic secondary_select,
	input wire logic output_drive_enable_n,
	input wire logic write_strobe_n,
	input wire logic low_byte_lane_n,
	input wire logic high_byte_lane_n,
	input wire logic [psc_pkg::DATA_W-1:0] mem_data_o,
	input wire logic mem_data_oe
);
	localparam int C_STB = SPEED_70 ? psc_pkg::C70_STROBE : psc_pkg::C55_STROBE;
	localparam int C_RC = SPEED_70 ? psc_pkg::C70_READ_CYCLE : psc_pkg::C55_READ_CYCLE;
	localparam int C_RD = psc_pkg::C55_ACCESS + psc_pkg::SYNC_STAGES;
	localparam int C_MAX = psc_pkg::C_STROBE_MAX;
	logic [9:0] lo_cnt;
	logic [9:0] sel_cnt;

	// Counts how long the strobe and the primary select have been low.
	always_ff @(posedge clock) begin
		lo_cnt <= (srst || write_strobe_n) ? 10'h000 : lo_cnt + 10'h001;
	end
	always_ff @(posedge clock) begin
		sel_cnt <= (srst || primary_select_n) ? 10'h000 : sel_cnt + 10'h001;
	end

	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	sequence s_take;
		req_valid && req_ready;
	endsequence
	sequence s_in_write;
		!write_strobe_n || $rose(write_strobe_n);
	endsequence

	strobe_len_a: assert property ($rose(write_strobe_n) |-> lo_cnt >= C_STB && lo_cnt <= C_MAX)
		else $error("write strobe pulse length out of range");
	sel_len_a: assert property ($rose(primary_select_n) |-> sel_cnt >= C_RC && sel_cnt <= C_MAX)
		else $error("select low time out of range");
	sel_write_a: assert property (!write_strobe_n |-> !primary_select_n && secondary_select)
		else $error("selects inactive during write strobe");
	lanes_write_a: assert property (s_in_write |-> $stable({low_byte_lane_n, high_byte_lane_n}))
		else $error("byte lanes moved during write");
	addr_write_a: assert property (s_in_write |-> $stable(mem_addr))
		else $error("address moved during write");
	data_write_a: assert property (s_in_write |-> mem_data_oe && $stable(mem_data_o))
		else $error("write data not held");
	oe_write_a: assert property (!write_strobe_n |-> output_drive_enable_n)
		else $error("output enable low during write");
	strobe_read_a: assert property (!output_drive_enable_n |-> write_strobe_n)
		else $error("strobe low during read");
	addr_sel_a: assert property (s_take |=> !primary_select_n && mem_addr == $past(req_addr))
		else $error("address not valid at select");
	lane_map_a: assert property (s_take |=> {high_byte_lane_n, low_byte_lane_n} == ~$past(req_lanes))
		else $error("lane pins do not follow request");
	wdata_take_a: assert property (s_take ##0 req_write |=> mem_data_o == $past(req_wdata))
		else $error("write data differs from request");
	read_wait_a: assert property (rsp_valid && !rsp_write |-> sel_cnt >= C_RD)
		else $error("read answered before access time");
endmodule

bind psc_host psc_host_props #(.SPEED_70(SPEED_70)) i_psc_host_props (.clock, .srst, .req_valid,
	.req_ready, .req_write, .req_addr, .req_wdata, .req_lanes, .rsp_valid, .rsp_write, .mem_addr,
	.primary_select_n, .secondary_select, .output_drive_enable_n, .write_strobe_n,
	.low_byte_lane_n, .high_byte_lane_n, .mem_data_o, .mem_data_oe);

// [sim/psc_mem_model.sv]
// Behavioural model of the pseudo-static RAM as seen at its pins.
`timescale 1ns/1ps
module psc_mem_model #(
	parameter int T_ACC = 55
) (
	input wire logic [18:0] mem_addr,
	input wire logic primary_select_n,
	input wire logic secondary_select,
	input wire logic output_drive_enable_n,
	input wire logic write_strobe_n,
	input wire logic low_byte_lane_n,
	input wire logic high_byte_lane_n,
	input wire logic [15:0] dq,
	output logic [15:0] bus
);
	logic [15:0] mem [int];
	logic [15:0] wv;
	logic [15:0] rd;
	logic [1:0] drv;
	logic [1:0] was;
	logic sel;
	logic wr;
	logic ok;
	realtime t_chg;

	// Cells never decay here, so refresh always has room.
	assign sel = !primary_select_n && secondary_select;
	assign wr = sel && !write_strobe_n && !(low_byte_lane_n && high_byte_lane_n);

	always @(mem_addr, sel, low_byte_lane_n, high_byte_lane_n, output_drive_enable_n,
		write_strobe_n) begin
		t_chg = $realtime;
	end

	always @(wr, mem_addr, dq, low_byte_lane_n, high_byte_lane_n) begin
		if (wr) begin
			wv = mem.exists(mem_addr) ? mem[mem_addr] : 16'h0000;
			wv[7:0] = low_byte_lane_n ? wv[7:0] : dq[7:0];
			wv[15:8] = high_byte_lane_n ? wv[15:8] : dq[15:8];
			mem[mem_addr] = wv;
		end
	end

	// A lane that stops driving shows the inverse of its last value.
	initial begin
		bus = 16'h5a5a;
		was = 2'b00;
		forever begin
			#1;
			rd = mem.exists(mem_addr) ? mem[mem_addr] : 16'h0000;
			ok = sel && !output_drive_enable_n && write_strobe_n && ($realtime - t_chg >= T_ACC);
			drv = {ok && !high_byte_lane_n, ok && !low_byte_lane_n};
			for (int k = 0; k < 2; k++) begin
				if (drv[k]) begin
					bus[k*8 +: 8] = rd[k*8 +: 8];
				end else if (was[k]) begin
					bus[k*8 +: 8] = ~bus[k*8 +: 8];
				end
			end
			was = drv;
		end
	end
endmodule

// [sim/tb.sv]
// Self-checking testbench of the pseudo-static RAM host controller.
`timescale 1ns/1ps
module tb;
	logic clock, srst, req_valid, req_ready, req_write, rsp_valid, rsp_write, mem_data_oe;
	logic primary_select_n, secondary_select, output_drive_enable_n, write_strobe_n;
	logic low_byte_lane_n, high_byte_lane_n, mem_addr_o;
	logic [18:0] req_addr, mem_addr;
	logic [15:0] req_wdata, rsp_rdata, mem_data_i, mem_data_o, bus;
	logic [1:0] req_lanes;
	logic [31:0] r;
	logic [15:0] shadow [int];
	int errors, cmp_count, seed, lat;

	assign mem_data_i = mem_data_oe ? mem_data_o : bus;

	psc_host #(.SPEED_70(1'b0)) i_psc_host (.clock, .srst, .req_valid, .req_ready, .req_write,
		.req_addr, .req_wdata, .req_lanes, .rsp_valid, .rsp_write, .rsp_rdata, .mem_addr_o,
		.mem_addr, .primary_select_n, .secondary_select, .output_drive_enable_n,
		.write_strobe_n, .low_byte_lane_n, .high_byte_lane_n, .mem_data_i, .mem_data_o,
		.mem_data_oe);
	psc_mem_model #(.T_ACC(55)) i_psc_mem_model (.mem_addr, .primary_select_n,
		.secondary_select, .output_drive_enable_n, .write_strobe_n, .low_byte_lane_n,
		.high_byte_lane_n, .dq(mem_data_i), .bus);

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic logic [15:0] lmask(input logic [1:0] l);
		return {{8{l[1]}}, {8{l[0]}}};
	endfunction

	// Runs one access from a falling edge and checks its answer.
	task automatic acc(input logic w, input logic [18:0] a, input logic [15:0] d,
		input logic [1:0] l);
		logic [15:0] old;
		int n;
		req_valid = 1'b1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		req_lanes = l;
		n = 0;
		while (req_ready !== 1'b1 && n < 50) begin
			@(negedge clock);
			n++;
		end
		@(negedge clock);
		req_valid = 1'b0;
		lat = 1;
		while (rsp_valid !== 1'b1 && lat < 100) begin
			@(negedge clock);
			lat++;
		end
		old = shadow.exists(a) ? shadow[a] : 16'h0000;
		if (w) begin
			chk({rsp_valid, rsp_write, lat[7:0]}, {2'b11, 8'(psc_pkg::C55_STROBE + 3)});
			shadow[a] = (old & ~lmask(l)) | (d & lmask(l));
		end else begin
			chk({rsp_valid, rsp_write, rsp_rdata}, {2'b10, old & lmask(l)});
			chk(lat, psc_pkg::C55_ACCESS + psc_pkg::SYNC_STAGES + 3);
		end
		@(negedge clock);
	endtask

	task automatic final_report();
		$display("errors=%0d comparisons=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		errors++;
		final_report();
	end

	initial begin
		seed = 70128;
		errors = 0;
		cmp_count = 0;
		srst = 1'b1;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = 19'h0_0000;
		req_wdata = 16'h0000;
		req_lanes = 2'b00;
		repeat (2) @(negedge clock);
		srst = 1'b0;
		chk({primary_select_n, secondary_select, output_drive_enable_n, write_strobe_n,
			low_byte_lane_n, high_byte_lane_n, mem_data_oe, rsp_valid, req_ready},
			32'h0000_0179);
		chk(mem_addr_o, 32'h0000_0001);
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			acc(1'b1, 19'h0_0005, r[15:0], i[1:0]);
			for (int j = 0; j < 4; j++) begin
				acc(1'b0, 19'h0_0005, 16'h0000, j[1:0]);
			end
		end
		acc(1'b1, 19'h7_ffff, 16'hc3a5, 2'b11);
		acc(1'b1, 19'h0_0000, 16'h5e61, 2'b11);
		acc(1'b0, 19'h7_ffff, 16'h0000, 2'b11);
		acc(1'b0, 19'h0_0000, 16'h0000, 2'b11);
		repeat (60) begin
			r = $random(seed);
			acc(r[20], {16'h0000, r[23:21]}, r[15:0], r[25:24]);
		end
		final_report();
	end
endmodule
